//--- shared/dtdu_pkg.sv
package dtdu_pkg;
	// register offsets on the byte-wide register port
	localparam logic [7:0] OFS_SHARED_CTRL = 8'h01;
	localparam logic [7:0] OFS_LONG_CTRL = 8'h02;
	localparam logic [7:0] OFS_RELOAD_HIGH = 8'h04;
	localparam logic [7:0] OFS_RELOAD_LOW = 8'h05;
	localparam logic [7:0] OFS_CAPTURE_HIGH = 8'h06;
	localparam logic [7:0] OFS_CAPTURE_LOW = 8'h07;
	// shared control fields
	localparam int SC_MODE = 7;
	localparam int SC_INPUT_SEL = 6;
	localparam int SC_LOGIC_HI = 5;
	localparam int SC_LOGIC_LO = 4;
	localparam int SC_SUB_HI = 3;
	localparam int SC_SUB_LO = 2;
	localparam int SC_SHORT_INIT = 1;
	localparam int SC_LONG_INIT = 0;
	// long control fields
	localparam int LC_ENABLE = 7;
	localparam int LC_CAPT_ONCE = 6;
	localparam int LC_STATUS = 5;
	localparam int LC_MODULO = 4;
	localparam int LC_CAPT_IRQ_EN = 2;
	localparam int LC_TOUT_IRQ_EN = 1;
	localparam logic [7:0] SHARED_CTRL_RESET = 8'h00;
	localparam logic [7:0] LONG_CTRL_RESET = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'hff;
	localparam logic [15:0] COUNT_FULL = 16'hffff;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	// combine logic / edge select codes
	localparam logic [1:0] CMB_AND = 2'h0;
	localparam logic [1:0] CMB_OR = 2'h1;
	localparam logic [1:0] CMB_NOR = 2'h2;
	localparam logic [1:0] CMB_NAND = 2'h3;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	// transmit sub-modes
	localparam logic [1:0] SUB_NORMAL = 2'h0;
	localparam logic [1:0] SUB_PING_PONG = 2'h1;
	localparam logic [1:0] SUB_FORCE_0 = 2'h2;
	localparam logic [1:0] SUB_FORCE_1 = 2'h3;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dtdu_req_t;

	typedef struct packed {
		logic short_counter_output;
		logic long_counter_output;
		logic combined_counter_output;
	} dtdu_outs_t;

	typedef struct packed {
		logic timeout_irq;
		logic capture_irq;
		logic short_restart;
	} dtdu_events_t;
endpackage

//--- src/dtdu_timer.sv
`timescale 1ns/1ps
// Function
// (R1) transmit: logic field combines short and long outputs by AND, OR, NOR, NAND
// (R2) demodulation: same field selects falling, rising or both edges
// (R3) sub-mode selects ping-pong or normal; writing normal ends ping-pong
// (R4) sub-mode 10 forces long output 0, 11 forces it 1, enabled or not
// (R5) demodulation: sub-mode sets the glitch filter width
// (R6) short counter start drives its output to the short initial level
// (R7) short counter disabled: output is inverse of short initial level
// (R8) demodulation: rising edge sets rise flag; writing 1 clears it
// (R9) demodulation: falling edge sets fall flag; writing 1 clears it
// (R10) long initial level acts in normal/ping-pong: inverse disabled, value on start
// (R11) software leaves initial-level bits alone while counters run
// (R12) long enable loads high*256+low and drives output to initial level
// (R13) long count reaching 0 toggles output, interrupts if enabled, sets status
// (R14) after zero: single-pass stops, modulo-N reloads and continues
// (R15) reload bytes writable any time; used only at next load
// (R16) software avoids writing reload bytes at the load moment
// (R17) software never programs an initial count of 1
// (R18) initial count 0 wraps to ffff without a timeout
// (R19) software sets both reload bytes to ff before demodulation
// (R20) demodulation: first edge captures, reloads and starts the counter
// (R21) later edges capture complement, set flag, interrupt, reload ffff
// (R22) capture high holds upper byte, capture low holds lower byte
module dtdu_timer
	import dtdu_pkg::*;
#(
	parameter int TICK_DIV = 1,
	parameter int GLITCH_STEP = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input dtdu_pkg::dtdu_req_t req,
	output logic [7:0] rd_data,
	input wire logic short_enable,
	input wire logic short_timeout,
	input wire logic demod_in_primary,
	input wire logic demod_in_alt,
	output dtdu_pkg::dtdu_outs_t outs,
	output dtdu_pkg::dtdu_events_t events
);
	import dtdu_pkg::*;

	logic rst_meta, rst_sync_n;
	logic [7:0] shared_timer_control, next_shared_timer_control;
	logic [7:0] long_timer_control, next_long_timer_control;
	logic [7:0] long_reload_high_byte, next_long_reload_high_byte;
	logic [7:0] long_reload_low_byte, next_long_reload_low_byte;
	logic [7:0] capture_high_byte, next_capture_high_byte;
	logic [7:0] capture_low_byte, next_capture_low_byte;
	logic [15:0] long_counter, next_long_counter;
	logic running, next_running;
	logic pp_wait, next_pp_wait;
	logic armed, next_armed;
	logic long_en_q, next_long_en_q;
	logic short_en_q, next_short_en_q;
	logic long_out, next_long_out;
	logic short_out, next_short_out;
	logic filt, next_filt;
	logic filt_q, next_filt_q;
	logic [7:0] glitch_cnt, next_glitch_cnt;
	logic [15:0] tick_cnt, next_tick_cnt;
	logic [7:0] next_rd_data;
	dtdu_events_t next_events;

	////////////////////////////////////////////////////////////////////////
	// reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////
	logic demod, tick, rise, fall, sel_edge, load_now;
	logic [1:0] logic_sel, sub_sel;
	logic [15:0] reload_value;
	logic [7:0] glitch_width;
	logic raw_in, wr_sc, wr_lc;

	always_comb begin
		demod = shared_timer_control[SC_MODE];
		logic_sel = shared_timer_control[SC_LOGIC_HI:SC_LOGIC_LO];
		sub_sel = shared_timer_control[SC_SUB_HI:SC_SUB_LO];
		// reload bytes are only sampled here, at the load itself (R15)
		reload_value = {long_reload_high_byte, long_reload_low_byte}; // R12
		glitch_width = 8'(int'(sub_sel) * GLITCH_STEP); // R5
		raw_in = shared_timer_control[SC_INPUT_SEL] ? demod_in_alt
			: demod_in_primary;
		tick = (tick_cnt == 16'(TICK_DIV - 1));
		wr_sc = req.wr && req.addr == OFS_SHARED_CTRL;
		wr_lc = req.wr && req.addr == OFS_LONG_CTRL;
		rise = filt && !filt_q;
		fall = !filt && filt_q;
		case (logic_sel) // R2
			EDGE_FALL: sel_edge = fall;
			EDGE_RISE: sel_edge = rise;
			EDGE_BOTH: sel_edge = rise || fall;
			default: sel_edge = 1'b0;
		endcase
		load_now = long_timer_control[LC_ENABLE] && !long_en_q;
	end

	always_comb begin
		next_shared_timer_control = shared_timer_control;
		next_long_timer_control = long_timer_control;
		next_long_reload_high_byte = long_reload_high_byte;
		next_long_reload_low_byte = long_reload_low_byte;
		next_capture_high_byte = capture_high_byte;
		next_capture_low_byte = capture_low_byte;
		next_long_counter = long_counter;
		next_running = running;
		next_pp_wait = pp_wait;
		next_armed = armed;
		next_long_out = long_out;
		next_short_out = short_out;
		next_events = '0;
		next_rd_data = 8'h00;
		next_tick_cnt = tick ? 16'h0000 : tick_cnt + 16'h0001;
		next_long_en_q = long_timer_control[LC_ENABLE];
		next_short_en_q = short_enable;
		next_filt_q = filt;
		next_filt = filt;
		next_glitch_cnt = 8'h00;
		// glitch filter: input must differ for the width before it passes
		if (raw_in != filt) begin
			if (glitch_cnt >= glitch_width) begin // R5
				next_filt = raw_in;
			end else begin
				next_glitch_cnt = glitch_cnt + 8'h01;
			end
		end

		// register writes; flag and status clears by writing one
		if (wr_sc) begin
			next_shared_timer_control = req.wdata;
			if (demod) begin
				next_shared_timer_control[SC_SHORT_INIT] =
					shared_timer_control[SC_SHORT_INIT]
					&& !req.wdata[SC_SHORT_INIT]; // R8
				next_shared_timer_control[SC_LONG_INIT] =
					shared_timer_control[SC_LONG_INIT]
					&& !req.wdata[SC_LONG_INIT]; // R9
			end
			if (req.wdata[SC_SUB_HI:SC_SUB_LO] != SUB_PING_PONG) begin
				next_pp_wait = 1'b0; // R3
			end
		end
		if (wr_lc) begin
			next_long_timer_control = req.wdata;
			next_long_timer_control[LC_STATUS] =
				long_timer_control[LC_STATUS] && !req.wdata[LC_STATUS];
		end
		if (req.wr && req.addr == OFS_RELOAD_HIGH) begin
			next_long_reload_high_byte = req.wdata; // R15
		end
		if (req.wr && req.addr == OFS_RELOAD_LOW) begin
			next_long_reload_low_byte = req.wdata; // R15
		end
		if (req.rd) begin
			case (req.addr)
				OFS_SHARED_CTRL: next_rd_data = shared_timer_control;
				OFS_LONG_CTRL: next_rd_data = long_timer_control;
				OFS_RELOAD_HIGH: next_rd_data = long_reload_high_byte;
				OFS_RELOAD_LOW: next_rd_data = long_reload_low_byte;
				OFS_CAPTURE_HIGH: next_rd_data = capture_high_byte;
				OFS_CAPTURE_LOW: next_rd_data = capture_low_byte;
				default: next_rd_data = 8'h00;
			endcase
		end

		// short counter output level
		if (!short_enable) begin
			next_short_out = !shared_timer_control[SC_SHORT_INIT]; // R7
		end else if (!short_en_q) begin
			next_short_out = shared_timer_control[SC_SHORT_INIT]; // R6
		end else if (short_timeout) begin
			next_short_out = !short_out;
		end

		// long counter
		if (!long_timer_control[LC_ENABLE]) begin
			next_running = 1'b0;
			next_armed = 1'b0;
			next_pp_wait = 1'b0;
			next_long_out = !shared_timer_control[SC_LONG_INIT]; // R10
		end else if (load_now) begin
			next_long_counter = reload_value; // R12
			next_long_out = shared_timer_control[SC_LONG_INIT]; // R12
			next_armed = demod;
			next_running = !demod && sub_sel != SUB_PING_PONG;
			next_pp_wait = !demod && sub_sel == SUB_PING_PONG;
		end else if (demod) begin
			if (sel_edge && armed) begin
				next_capture_high_byte = long_counter[15:8]; // R20
				next_capture_low_byte = long_counter[7:0]; // R20
				next_long_counter = reload_value; // R20
				next_running = 1'b1; // R20
			end else if (sel_edge && running
				&& !long_timer_control[LC_CAPT_ONCE]) begin
				next_capture_high_byte = ~long_counter[15:8]; // R21 R22
				next_capture_low_byte = ~long_counter[7:0]; // R21 R22
				if (rise) begin
					next_shared_timer_control[SC_SHORT_INIT] = 1'b1; // R8
				end
				if (fall) begin
					next_shared_timer_control[SC_LONG_INIT] = 1'b1; // R9
				end
				next_events.capture_irq =
					long_timer_control[LC_CAPT_IRQ_EN]; // R21
				next_long_counter = COUNT_FULL; // R21
			end else if (running && tick) begin
				next_long_counter = long_counter - COUNT_ONE;
			end
			if (sel_edge) begin
				next_armed = 1'b0;
			end
		end else if (pp_wait) begin
			// ping-pong: the long half starts when the short half ends
			if (short_timeout) begin
				next_pp_wait = 1'b0;
				next_running = 1'b1;
				next_long_counter = reload_value;
			end
		end else if (running && tick) begin
			// zero reached only from one; a loaded zero wraps quietly (R18)
			next_long_counter = long_counter - COUNT_ONE; // R18
			if (long_counter == COUNT_ONE) begin
				next_long_out = !long_out; // R13
				next_long_timer_control[LC_STATUS] = 1'b1; // R13
				next_events.timeout_irq =
					long_timer_control[LC_TOUT_IRQ_EN]; // R13
				if (sub_sel == SUB_PING_PONG) begin
					next_running = 1'b0;
					next_pp_wait = 1'b1;
					next_events.short_restart = 1'b1; // R3
				end else if (long_timer_control[LC_MODULO]) begin
					next_long_counter = reload_value; // R14
				end else begin
					next_running = 1'b0; // R14
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			shared_timer_control <= SHARED_CTRL_RESET;
			long_timer_control <= LONG_CTRL_RESET;
			long_reload_high_byte <= RELOAD_RESET;
			long_reload_low_byte <= RELOAD_RESET;
			capture_high_byte <= 8'h00;
			capture_low_byte <= 8'h00;
			long_counter <= 16'h0000;
			running <= 1'b0;
			pp_wait <= 1'b0;
			armed <= 1'b0;
			long_en_q <= 1'b0;
			short_en_q <= 1'b0;
			long_out <= 1'b1;
			short_out <= 1'b1;
			filt <= 1'b0;
			filt_q <= 1'b0;
			glitch_cnt <= 8'h00;
			tick_cnt <= 16'h0000;
			rd_data <= 8'h00;
			events <= '0;
		end else begin
			shared_timer_control <= next_shared_timer_control;
			long_timer_control <= next_long_timer_control;
			long_reload_high_byte <= next_long_reload_high_byte;
			long_reload_low_byte <= next_long_reload_low_byte;
			capture_high_byte <= next_capture_high_byte;
			capture_low_byte <= next_capture_low_byte;
			long_counter <= next_long_counter;
			running <= next_running;
			pp_wait <= next_pp_wait;
			armed <= next_armed;
			long_en_q <= next_long_en_q;
			short_en_q <= next_short_en_q;
			long_out <= next_long_out;
			short_out <= next_short_out;
			filt <= next_filt;
			filt_q <= next_filt_q;
			glitch_cnt <= next_glitch_cnt;
			tick_cnt <= next_tick_cnt;
			rd_data <= next_rd_data;
			events <= next_events;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output stage; forcing overrides the counter whether enabled or not
	logic long_final;
	always_comb begin
		case (sub_sel)
			SUB_FORCE_0: long_final = 1'b0; // R4
			SUB_FORCE_1: long_final = 1'b1; // R4
			default: long_final = long_out;
		endcase
		outs.short_counter_output = short_out;
		outs.long_counter_output = long_final;
		case (logic_sel) // R1
			CMB_AND: outs.combined_counter_output = short_out & long_final;
			CMB_OR: outs.combined_counter_output = short_out | long_final;
			CMB_NOR: outs.combined_counter_output = ~(short_out | long_final);
			CMB_NAND: outs.combined_counter_output = ~(short_out & long_final);
			default: outs.combined_counter_output = 1'b0;
		endcase
	end
endmodule

//--- test/dtdu_timer_assertions.sv
`timescale 1ns/1ps
module dtdu_chk #(
	parameter int TICK_DIV = 1,
	parameter int GLITCH_STEP = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	input dtdu_pkg::dtdu_req_t req,
	input wire logic short_enable,
	input dtdu_pkg::dtdu_outs_t outs,
	input dtdu_pkg::dtdu_events_t events
);
	import dtdu_pkg::*;
	// shadows of written control bytes; flags set by hardware are not tracked
	logic [7:0] sc;
	logic [7:0] lc;
	logic [7:0] next_sc;
	logic [7:0] next_lc;
	logic so;
	logic lo;
	always_comb begin
		next_sc = (req.wr && req.addr == OFS_SHARED_CTRL) ? req.wdata : sc;
		next_lc = (req.wr && req.addr == OFS_LONG_CTRL) ? req.wdata : lc;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sc <= SHARED_CTRL_RESET;
			lc <= LONG_CTRL_RESET;
		end else begin
			sc <= next_sc;
			lc <= next_lc;
		end
	end
	assign so = outs.short_counter_output;
	assign lo = outs.long_counter_output;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	////////////////////////////////////////
	combine_logic_a: assert property (
		!sc[SC_MODE] && $stable(sc) |-> outs.combined_counter_output ==
		(sc[5] ^ ((sc[5] ^ sc[4]) ? so | lo : so & lo))
	) else $error("combined output does not match logic select");
	force_level_a: assert property (
		!sc[SC_MODE] && sc[SC_SUB_HI] && $stable(sc) |-> lo == sc[SC_SUB_LO]
	) else $error("forced long output level wrong");
	short_idle_a: assert property (
		(!sc[SC_MODE] && !short_enable && $stable(sc))[*3] |->
		so == !sc[SC_SHORT_INIT]
	) else $error("idle short output not inverse of initial level");
	short_start_a: assert property (
		!sc[SC_MODE] && $stable(sc) && $rose(short_enable) |->
		##[1:2] so == sc[SC_SHORT_INIT]
	) else $error("short output missed initial level on start");
	long_idle_a: assert property (
		(!sc[SC_MODE] && !sc[SC_SUB_HI] && !lc[LC_ENABLE] && $stable(sc))[*4]
		|-> lo == !sc[SC_LONG_INIT]
	) else $error("idle long output not inverse of initial level");
	timeout_cause_a: assert property (
		events.timeout_irq && !sc[SC_SUB_HI] |->
		$past(lc[LC_TOUT_IRQ_EN]) && lo != $past(lo)
	) else $error("timeout pulse without enable or output toggle");
	single_pass_a: assert property (
		events.timeout_irq && !lc[LC_MODULO]
		&& sc[SC_SUB_HI:SC_SUB_LO] != SUB_PING_PONG
		|=> !events.timeout_irq [*8]
	) else $error("single-pass counter fired again");
	capture_cause_a: assert property (
		events.capture_irq |-> sc[SC_MODE] && lc[LC_CAPT_IRQ_EN] &&
		!lc[LC_CAPT_ONCE]
	) else $error("capture pulse outside enabled demodulation");
	cover property (events.timeout_irq && lc[LC_MODULO]);
	cover property (events.capture_irq);
	cover property (events.short_restart);
	cover property (!sc[SC_MODE] && sc[SC_SUB_HI] && lc[LC_ENABLE]);
endmodule
bind dtdu_timer dtdu_chk #(.TICK_DIV(TICK_DIV), .GLITCH_STEP(GLITCH_STEP))
	u_chk (.clk(clk), .rst_n(rst_n), .req(req), .short_enable(short_enable),
	.outs(outs), .events(events));

//--- test/dual_timer_transmit_demod_unit_bench.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
	cmp_count++; \
	if ((g) !== (e)) begin \
		mismatches++; \
		$display("ERROR %s expected %h seen %h", nm, e, g); \
	end \
end
module dual_timer_transmit_demod_unit_bench;
	import dtdu_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	dtdu_req_t req = '0;
	logic [7:0] rd_data;
	logic short_enable = 1'b0;
	logic short_timeout = 1'b0;
	logic demod_in_primary = 1'b0;
	logic demod_in_alt;
	dtdu_outs_t outs;
	dtdu_events_t events;
	int mismatches = 0;
	int cmp_count = 0;
	int n, n1, nn, mm, k;
	logic [7:0] d;
	logic [7:0] s;
	always #5 clk = ~clk;
	// unselected input always differs, so a wrong select shows up
	assign demod_in_alt = ~demod_in_primary;
	localparam int GLITCH_STEP = 4;
	dtdu_timer #(.TICK_DIV(1), .GLITCH_STEP(GLITCH_STEP)) u_dtdu_timer (
		.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data),
		.short_enable(short_enable), .short_timeout(short_timeout),
		.demod_in_primary(demod_in_primary), .demod_in_alt(demod_in_alt),
		.outs(outs), .events(events));
	////////////////////////////////////////
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(negedge clk);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge clk);
		req.wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(negedge clk);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req.rd = 1'b0;
		d = rd_data;
	endtask
	// n comes back equal to lim when no pulse arrived
	task automatic wait_ev(input bit cap, input int lim);
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while ((cap ? events.capture_irq : events.timeout_irq) !== 1'b1
			&& n < lim);
	endtask
	function automatic logic cmb(input logic [1:0] f, input logic a,
		input logic b);
		return f[1] ^ ((f[0] ^ f[1]) ? a | b : a & b);
	endfunction
	// whether a change to level lvl is an edge that select f responds to
	function automatic logic hit(input logic [1:0] f, input logic lvl);
		return f == EDGE_BOTH || (f == EDGE_RISE && lvl)
			|| (f == EDGE_FALL && !lvl);
	endfunction
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		end_of_test();
	end
	initial begin
		void'($urandom(89));
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		`CHK("reset outputs", 3'b111, outs);
		for (int i = 1; i < 8; i++) begin
			rd(8'(i));
			`CHK("reset value", (i == 4 || i == 5) ? 8'hff : 8'h00, d);
		end
		for (int i = 0; i < 12; i++) begin
			s = {2'b00, 2'(i % 4), 2'b00, 2'($urandom)};
			wr(OFS_SHARED_CTRL, s);
			repeat (4) @(negedge clk);
			`CHK("short idle", ~s[1], outs.short_counter_output);
			`CHK("long idle", ~s[0], outs.long_counter_output);
			`CHK("combined", cmb(s[5:4], ~s[1], ~s[0]), outs[0]);
		end
		for (int i = 0; i < 4; i++) begin
			wr(OFS_LONG_CTRL, {i[1], 7'h00});
			wr(OFS_SHARED_CTRL, {4'h0, 1'b1, i[0], 2'h0});
			`CHK("forced level", i[0], outs.long_counter_output);
		end
		// stop the long counter before the initial level is touched
		wr(OFS_LONG_CTRL, 8'h00);
		s = 8'($urandom) & 8'h02;
		wr(OFS_SHARED_CTRL, s);
		short_enable = 1'b1;
		repeat (2) @(negedge clk);
		`CHK("short start", s[1], outs.short_counter_output);
		short_enable = 1'b0;
		nn = 12 + $urandom % 400;
		wr(OFS_SHARED_CTRL, 8'h01);
		wr(OFS_RELOAD_HIGH, 8'(nn >> 8));
		wr(OFS_RELOAD_LOW, 8'(nn));
		wr(OFS_LONG_CTRL, 8'h82);
		repeat (1) @(negedge clk);
		`CHK("long start", 1'b1, outs.long_counter_output);
		wait_ev(0, 500);
		`CHK("timeout delay", nn, n);
		`CHK("long toggled", 1'b0, outs.long_counter_output);
		wait_ev(0, 100);
		`CHK("single pass", 100, n);
		rd(OFS_LONG_CTRL);
		`CHK("status set", 1'b1, d[LC_STATUS]);
		wr(OFS_LONG_CTRL, 8'h20);
		rd(OFS_LONG_CTRL);
		`CHK("status clear", 8'h00, d);
		mm = 12 + $urandom % 40;
		wr(OFS_LONG_CTRL, 8'h92);
		wait_ev(0, 500);
		wait_ev(0, 500);
		n1 = n;
		wr(OFS_RELOAD_HIGH, 8'h00);
		wr(OFS_RELOAD_LOW, 8'(mm));
		wait_ev(0, 500);
		`CHK("reload deferred", n1, n + 4);
		wait_ev(0, 500);
		`CHK("modulo reload", n1 - nn + mm, n);
		wr(OFS_LONG_CTRL, 8'h00);
		wr(OFS_RELOAD_LOW, 8'h00);
		wr(OFS_LONG_CTRL, 8'h82);
		wait_ev(0, 300);
		`CHK("zero wraps quietly", 300, n);
		wr(OFS_LONG_CTRL, 8'h00);
		wr(OFS_RELOAD_HIGH, 8'hff);
		wr(OFS_RELOAD_LOW, 8'hff);
		wr(OFS_SHARED_CTRL, {2'b10, EDGE_BOTH, 4'h0});
		wr(OFS_LONG_CTRL, 8'h84);
		k = 20 + $urandom % 40;
		demod_in_primary = 1'b1;
		wait_ev(1, k);
		`CHK("first edge quiet", k, n);
		demod_in_primary = 1'b0;
		wait_ev(1, 40);
		`CHK("capture pulse", 1'b1, n < 40);
		rd(OFS_CAPTURE_HIGH);
		s = d;
		rd(OFS_CAPTURE_LOW);
		`CHK("capture", 1'b1, {s, d} + 3 >= k && {s, d} <= k + 3);
		demod_in_primary = 1'b1;
		wait_ev(1, 40);
		rd(OFS_SHARED_CTRL);
		`CHK("edge flags", 8'ha3, d);
		wr(OFS_SHARED_CTRL, 8'ha3);
		rd(OFS_SHARED_CTRL);
		`CHK("flags cleared", 8'ha0, d);
		for (int e = 0; e < 4; e++) begin
			wr(OFS_SHARED_CTRL, {2'b10, 2'(e), 4'h0});
			repeat (2) begin
				demod_in_primary = ~demod_in_primary;
				wait_ev(1, 40);
				`CHK("edge select", hit(2'(e), demod_in_primary), n < 40);
			end
		end
		// a pulse as wide as the filter step must vanish
		wr(OFS_SHARED_CTRL, {2'b10, EDGE_BOTH, 2'b01, 2'b00});
		demod_in_primary = 1'b0;
		repeat (GLITCH_STEP) @(negedge clk);
		demod_in_primary = 1'b1;
		wait_ev(1, 40);
		`CHK("glitch filtered", 40, n);
		demod_in_primary = 1'b0;
		wait_ev(1, 40);
		`CHK("wide edge passes", 1'b1, n < 40);
		wr(OFS_LONG_CTRL, 8'hc4);
		demod_in_primary = 1'b1;
		wait_ev(1, 40);
		`CHK("capture once", 40, n);
		// leave demodulation with both flags cleared first
		wr(OFS_LONG_CTRL, 8'h00);
		wr(OFS_SHARED_CTRL, 8'h83);
		wr(OFS_SHARED_CTRL, {4'h0, SUB_PING_PONG, 2'b00});
		wr(OFS_RELOAD_HIGH, 8'h00);
		wr(OFS_RELOAD_LOW, 8'(mm));
		wr(OFS_LONG_CTRL, 8'h82);
		wait_ev(0, 50);
		`CHK("ping-pong wait", 50, n);
		short_timeout = 1'b1;
		@(negedge clk);
		short_timeout = 1'b0;
		wait_ev(0, 100);
		`CHK("ping-pong half", mm, n);
		`CHK("ping-pong restart", 1'b1, events.short_restart);
		wr(OFS_SHARED_CTRL, {4'h0, SUB_NORMAL, 2'b00});
		short_timeout = 1'b1;
		@(negedge clk);
		short_timeout = 1'b0;
		wait_ev(0, 100);
		`CHK("ping-pong ended", 100, n);
		end_of_test();
	end
endmodule
